// *** hw/input_delay_filter_16ch.sv ***
// Input delay filter for 16 digital inputs, one shared parameter byte.
// Assumes parameter writes arrive on the module clock from the backplane
// logic; the raw inputs come from pins and are synchronised here.
//
// Functional notes
// - Bits 3..0 select the delay, codes 06h..0Ch for 0.4, 0.7, 1.5, 3, 6, 12 and 23 ms, and no other code is allowed.
// - Bit 7 at 0 blocks the filter so inputs pass straight through, at 1 the delay is applied.
// - One delay and enable setting governs every channel alike.
// - After reset the parameter byte holds 89h, filter on with 3 ms.
// - The byte is written as record set 01h, CANopen index 3100h or EtherCAT subindex 01h.
// - With the filter on, a level change reaches the image only after holding for the delay.
// - The delay acts on rising and falling edges alike, within 0.4 ms to 23 ms.
// - The filtered levels form a 16-bit image, bit n for channel n.
`timescale 1ns/1ps
`default_nettype none
`include "input_delay_filter_map.svh"

module input_delay_filter_16ch
   import input_delay_filter_pkg::*;
#(
   parameter int P_CYC_0P4 = `DLY_0P4_US * `IDF_CLK_MHZ,
   parameter int P_CYC_0P7 = `DLY_0P7_US * `IDF_CLK_MHZ,
   parameter int P_CYC_1P5 = `DLY_1P5_US * `IDF_CLK_MHZ,
   parameter int P_CYC_3   = `DLY_3_US   * `IDF_CLK_MHZ,
   parameter int P_CYC_6   = `DLY_6_US   * `IDF_CLK_MHZ,
   parameter int P_CYC_12  = `DLY_12_US  * `IDF_CLK_MHZ,
   parameter int P_CYC_23  = `DLY_23_US  * `IDF_CLK_MHZ
)(
   input  wire logic           I_CLK,
   input  wire logic           I_NRST,
   input  wire logic           I_CE,
   input  wire logic [15:0]    I_DIGITAL_INPUT_CHANNEL,
   input  wire logic           I_PARAM_WR,
   input  wire param_path_type I_PARAM_PATH,
   input  wire logic [15:0]    I_PARAM_SELECT,
   input  wire logic [7:0]     I_PARAM_DATA,
   output var  logic [7:0]     O_INPUT_DELAY_CONFIG,
   output var  logic           O_PARAM_ACK,
   output var  logic           O_PARAM_NAK,
   output var  logic [15:0]    O_INPUT_IMAGE,
   output wire logic           O_FILTER_ACTIVE
);
   // ----------------------------------------------------------------
   // Parameter address decode
   // ----------------------------------------------------------------
   wire hit_record   = (I_PARAM_PATH == PATH_RECORD)   && (I_PARAM_SELECT == `SEL_RECORD_SET);
   wire hit_canopen  = (I_PARAM_PATH == PATH_CANOPEN)  && (I_PARAM_SELECT == `SEL_OBJECT_INDEX);
   wire hit_ethercat = (I_PARAM_PATH == PATH_ETHERCAT) && (I_PARAM_SELECT == `SEL_OBJECT_SUBINDEX);
   wire param_hit    = I_PARAM_WR && (hit_record || hit_canopen || hit_ethercat);

   // Reserved bits 6..4 never reach the decode
   wire delay_code_type new_code = I_PARAM_DATA[`CFG_CODE_MSB:`CFG_CODE_LSB];
   wire code_valid = (new_code >= `CODE_0P4) && (new_code <= `CODE_23);
   wire accept     = param_hit && code_valid;
   wire reject     = param_hit && !code_valid;

   // ----------------------------------------------------------------
   // Parameter byte
   // ----------------------------------------------------------------
   // A forbidden code is refused whole so the filter never runs on an
   // undefined delay; the previous setting stays in force.
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_INPUT_DELAY_CONFIG <= `CFG_RESET;
         O_PARAM_ACK          <= 1'b0;
         O_PARAM_NAK          <= 1'b0;
      end else if (I_CE) begin
         if (accept) begin
            O_INPUT_DELAY_CONFIG <= I_PARAM_DATA;
         end
         O_PARAM_ACK <= accept;
         O_PARAM_NAK <= reject;
      end
   end

   wire delay_code_type code = O_INPUT_DELAY_CONFIG[`CFG_CODE_MSB:`CFG_CODE_LSB];
   wire filter_en = O_INPUT_DELAY_CONFIG[`CFG_EN_BIT];
   assign O_FILTER_ACTIVE = filter_en;

   // ----------------------------------------------------------------
   // Delay selection
   // ----------------------------------------------------------------
   wire count_type limit =
      (code == `CODE_0P4) ? count_type'(P_CYC_0P4) :
      (code == `CODE_0P7) ? count_type'(P_CYC_0P7) :
      (code == `CODE_1P5) ? count_type'(P_CYC_1P5) :
      (code == `CODE_6)   ? count_type'(P_CYC_6)   :
      (code == `CODE_12)  ? count_type'(P_CYC_12)  :
      (code == `CODE_23)  ? count_type'(P_CYC_23)  :
                            count_type'(P_CYC_3);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Raw pins are asynchronous; the first stage feeds only the second.
   image_type sync_meta;
   image_type sync_in;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sync_meta <= '0;
         sync_in   <= '0;
      end else if (I_CE) begin
         sync_meta <= I_DIGITAL_INPUT_CHANNEL;
         sync_in   <= sync_meta;
      end
   end

   // ----------------------------------------------------------------
   // Channel filters
   // ----------------------------------------------------------------
   // Every channel sees the same enable and limit wires.
   image_type filtered;

   genvar ch;
   generate
      for (ch = 0; ch < `IDF_CHANNELS; ch++) begin : g_chan
         debounce_channel u_chan (
            .clk    (I_CLK),
            .nrst   (I_NRST),
            .ce     (I_CE),
            .sample (sync_in[ch]),
            .enable (filter_en),
            .limit  (limit),
            .state  (filtered[ch])
         );
      end
   endgenerate

   always_comb begin
      O_INPUT_IMAGE = filtered;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   // Helper only read by the checks below
   logic written;
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         written <= 1'b0;
      end else if (I_CE && accept) begin
         written <= 1'b1;
      end
   end

   sequence s_good_write;
      I_CE && param_hit && code_valid;
   endsequence

   sequence s_bad_write;
      I_CE && param_hit && !code_valid;
   endsequence

   a_reset_default: assert property (!written |-> O_INPUT_DELAY_CONFIG == `CFG_RESET
      && limit == count_type'(P_CYC_3) && filter_en)
      else $error("parameter byte left its reset value without a write");
   a_good_write: assert property (s_good_write |=> O_INPUT_DELAY_CONFIG == $past(I_PARAM_DATA)
      && O_PARAM_ACK && !O_PARAM_NAK)
      else $error("valid parameter write not taken");
   a_bad_code_kept: assert property (s_bad_write |=> $stable(O_INPUT_DELAY_CONFIG)
      && O_PARAM_NAK && !O_PARAM_ACK)
      else $error("forbidden delay code was stored");
   a_foreign_ignored: assert property ((I_PARAM_WR && !param_hit) |=> $stable(O_INPUT_DELAY_CONFIG))
      else $error("write to another object changed the parameter byte");
   a_limit_23: assert property (code == `CODE_23 |-> limit == count_type'(P_CYC_23))
      else $error("23 ms code selected the wrong count");
   a_limit_0p4: assert property (code == `CODE_0P4 |-> limit == count_type'(P_CYC_0P4))
      else $error("0.4 ms code selected the wrong count");
   // A change of the reserved bits alone must leave the count untouched
   a_reserved_ignored: assert property ($changed(O_INPUT_DELAY_CONFIG[`CFG_RSV_MSB:`CFG_RSV_LSB])
      && $stable(code) |-> $stable(limit))
      else $error("reserved bits disturbed the delay decode");
   a_bypass_image: assert property ((I_CE && !filter_en) ##1 (I_CE && !filter_en)
      |=> O_INPUT_IMAGE == $past(sync_in))
      else $error("blocked filter did not pass inputs to the image");
   a_ce_freeze: assert property (!I_CE |=> $stable(O_INPUT_IMAGE) && $stable(O_INPUT_DELAY_CONFIG))
      else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

// *** include/input_delay_filter_map.svh ***
// Constants of the 16-channel input delay filter: offsets, codes, times.
// Assumes a 100 MHz module clock; times are kept in microseconds.
`ifndef INPUT_DELAY_FILTER_MAP_SVH
`define INPUT_DELAY_FILTER_MAP_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define IDF_CHANNELS        16
`define IDF_CNT_W           22
`define IDF_CLK_MHZ         100

// ----------------------------------------------------------------
// Parameter byte layout
// ----------------------------------------------------------------
`define CFG_RESET           8'h89
`define CFG_EN_BIT          7
`define CFG_CODE_MSB        3
`define CFG_CODE_LSB        0
`define CFG_RSV_MSB         6
`define CFG_RSV_LSB         4

// ----------------------------------------------------------------
// Parameter addressing on each access path
// ----------------------------------------------------------------
`define SEL_RECORD_SET      16'h0001
`define SEL_OBJECT_INDEX    16'h3100
`define SEL_OBJECT_SUBINDEX 16'h0001

// ----------------------------------------------------------------
// Delay codes and their times in microseconds
// ----------------------------------------------------------------
`define CODE_0P4            4'h6
`define CODE_0P7            4'h7
`define CODE_1P5            4'h8
`define CODE_3              4'h9
`define CODE_6              4'hA
`define CODE_12             4'hB
`define CODE_23             4'hC
`define DLY_0P4_US          400
`define DLY_0P7_US          700
`define DLY_1P5_US          1500
`define DLY_3_US            3000
`define DLY_6_US            6000
`define DLY_12_US           12000
`define DLY_23_US           23000

`endif

// *** include/input_delay_filter_pkg.sv ***
// Types shared by the input delay filter modules.
// Assumes the constant header is on the include path.
`include "input_delay_filter_map.svh"

package input_delay_filter_pkg;
   typedef logic [`IDF_CNT_W-1:0]    count_type;
   typedef logic [`CFG_CODE_MSB:0]   delay_code_type;
   typedef logic [`IDF_CHANNELS-1:0] image_type;
   typedef enum logic [1:0] {
      PATH_RECORD   = 2'h0,
      PATH_CANOPEN  = 2'h1,
      PATH_ETHERCAT = 2'h3
   } param_path_type;
endpackage

// *** hw/debounce_channel.sv ***
// One filtered input channel: a level change passes after it has held
// for limit cycles. Assumes sample is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "input_delay_filter_map.svh"

module debounce_channel
   import input_delay_filter_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire logic      ce,
   input  wire logic      sample,
   input  wire logic      enable,
   input  wire count_type limit,
   output var  logic      state
);
   count_type count;
   wire       differs = sample != state;
   wire       expired = count >= (limit - count_type'(1));

   // Same counter serves both edge directions
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= 1'b0;
         count <= '0;
      end else if (ce) begin
         if (!enable || (differs && expired)) begin
            state <= sample;
            count <= '0;
         end else if (differs) begin
            count <= count + count_type'(1);
         end else begin
            count <= '0;                               // Peak ended early
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_pending;
      ce && enable && differs && !expired;
   endsequence

   a_no_early_change: assert property (s_pending |=> state == $past(state))
      else $error("filtered state changed before delay ran out");
   a_bypass_follow: assert property ((ce && !enable) |=> state == $past(sample))
      else $error("blocked filter did not pass input");
   a_change_on_expiry: assert property ($changed(state) && $past(enable) |->
      $past(count) == $past(limit) - count_type'(1))
      else $error("state changed at wrong count");
endmodule
`default_nettype wire

// *** sim/param_master_model.sv ***
// Backplane head module model: writes the shared parameter byte.
// Assumes the bench calls write() and leaves these pins to this model.
`timescale 1ns/1ps
`default_nettype none

module param_master_model
   import input_delay_filter_pkg::*;
(
   input  wire logic           i_clk,
   input  wire logic           i_ack,
   input  wire logic           i_nak,
   output var  logic           o_wr,
   output var  param_path_type o_path,
   output var  logic [15:0]    o_select,
   output var  logic [7:0]     o_data
);
   initial begin
      o_wr = 1'b0;
      o_path = PATH_RECORD;
      o_select = 16'hFFFF;
      o_data = 8'hFF;
   end

   // Reserved bits go out as the caller gives them; only the F6h row sets them, with a valid code
   task automatic write(input param_path_type p, input logic [15:0] s, input logic [7:0] d,
                        output logic a, output logic n);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_path = p;
      o_select = s;
      o_data = d;
      @(negedge i_clk);
      a = i_ack;
      n = i_nak;
      o_wr = 1'b0;
      // Released lines flip so a stale value is never mistaken for data
      o_select = ~s;
      o_data = ~d;
   endtask
endmodule
`default_nettype wire

// *** sim/input_delay_filter_16ch_tb_top.sv ***
// Self-checking bench of the 16-channel input delay filter.
// Assumes short delay parameters 4..230 cycles replace the real counts.
`timescale 1ns/1ps
`default_nettype none

module input_delay_filter_16ch_tb_top
   import input_delay_filter_pkg::*;
;
   typedef struct {param_path_type p; logic [15:0] s; logic [7:0] d; logic a; logic n; int e;} row_type;
   localparam int C0P4 = 4, C0P7 = 7, C1P5 = 15, C3 = 30;
   localparam int C6 = 60, C12 = 120, C23 = 230;
   logic           I_CLK = 1'b0;
   logic           I_NRST = 1'b0;
   logic           I_CE = 1'b1;
   logic [15:0]    pins = 16'h0000;
   logic           wr, ack, nak, act, a, n;
   param_path_type path;
   logic [15:0]    sel, img;
   logic [7:0]     data, cfg, ecfg;
   int             errors = 0;
   int             n_compared = 0;
   int             cycles = 0;
   row_type        rows [14] = '{
      '{PATH_RECORD, 16'h0001, 8'h86, 1, 0, C0P4 + 2}, '{PATH_CANOPEN, 16'h3100, 8'h87, 1, 0, C0P7 + 2},
      '{PATH_ETHERCAT, 16'h0001, 8'h88, 1, 0, C1P5 + 2}, '{PATH_RECORD, 16'h0001, 8'h89, 1, 0, C3 + 2},
      '{PATH_RECORD, 16'h0001, 8'h8A, 1, 0, C6 + 2}, '{PATH_RECORD, 16'h0001, 8'h8B, 1, 0, C12 + 2},
      '{PATH_RECORD, 16'h0001, 8'h8C, 1, 0, C23 + 2}, '{PATH_RECORD, 16'h0001, 8'h05, 0, 1, C23 + 2},
      '{PATH_RECORD, 16'h0001, 8'h8D, 0, 1, C23 + 2}, '{PATH_RECORD, 16'h0002, 8'h09, 0, 0, C23 + 2},
      '{PATH_CANOPEN, 16'h0001, 8'h09, 0, 0, C23 + 2}, '{PATH_RECORD, 16'h0001, 8'h09, 1, 0, 3},
      '{PATH_RECORD, 16'h0001, 8'h86, 1, 0, C0P4 + 2}, '{PATH_RECORD, 16'h0001, 8'hF6, 1, 0, C0P4 + 2}};

   always #5 I_CLK = ~I_CLK;

   input_delay_filter_16ch #(.P_CYC_0P4(C0P4), .P_CYC_0P7(C0P7), .P_CYC_1P5(C1P5), .P_CYC_3(C3),
      .P_CYC_6(C6), .P_CYC_12(C12), .P_CYC_23(C23)) DUT (
      .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CE(I_CE), .I_DIGITAL_INPUT_CHANNEL(pins),
      .I_PARAM_WR(wr), .I_PARAM_PATH(path), .I_PARAM_SELECT(sel), .I_PARAM_DATA(data),
      .O_INPUT_DELAY_CONFIG(cfg), .O_PARAM_ACK(ack), .O_PARAM_NAK(nak),
      .O_INPUT_IMAGE(img), .O_FILTER_ACTIVE(act));

   param_master_model MASTER (.i_clk(I_CLK), .i_ack(ack), .i_nak(nak), .o_wr(wr),
      .o_path(path), .o_select(sel), .o_data(data));

   // ----------------------------------------
   // Checks and drivers
   // ----------------------------------------
   task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts edges until every channel shows p; that count must lie within one of e
   task automatic step(input logic [15:0] p, input int e);
      int k;
      k = 0;
      @(negedge I_CLK) pins = p;
      while (img !== p && k < 400) begin
         @(negedge I_CLK);
         k++;
      end
      chk(k >= e - 1 && k <= e + 1, k, e);
   endtask

   task automatic do_reset();
      @(negedge I_CLK) I_NRST = 1'b0;
      repeat (4) @(negedge I_CLK);
      chk(cfg === 8'h89 && img === 16'h0000 && act === 1'b1, 32'(cfg), 32'h89);
      I_NRST = 1'b1;
      ecfg = 8'h89;
      $display("reset test done");
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge I_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      do_reset();
      step(16'hA5C3, C3 + 2);
      step(16'h0000, C3 + 2);
      foreach (rows[i]) begin
         MASTER.write(rows[i].p, rows[i].s, rows[i].d, a, n);
         if (rows[i].a)
            ecfg = rows[i].d;
         chk(a === rows[i].a && n === rows[i].n, 32'({a, n}), 32'({rows[i].a, rows[i].n}));
         chk(cfg === ecfg && act === ecfg[7], 32'(cfg), 32'(ecfg));
         step(16'hA5C3, rows[i].e);
         step(16'h0000, rows[i].e);
      end
      $display("row test done");
      // Peak of two cycles against a four-cycle delay must vanish
      @(negedge I_CLK) pins = 16'hFFFF;
      repeat (2) @(negedge I_CLK);
      pins = 16'h0000;
      // Watched every cycle so a peak that slips through is seen
      repeat (10) begin
         @(negedge I_CLK);
         chk(img === 16'h0000, 32'(img), 32'h0);
      end
      $display("peak test done");
      I_CE = 1'b0;
      MASTER.write(PATH_RECORD, 16'h0001, 8'h8A, a, n);
      chk(a === 1'b0 && cfg === 8'hF6, 32'(cfg), 32'hF6);
      I_CE = 1'b1;
      $display("clock enable test done");
      do_reset();
      step(16'hFFFF, C3 + 2);
      final_report();
   end
endmodule
`default_nettype wire
